// ==== include/pbai_pkg.sv ====
`default_nettype none
package pbai_pkg;
  // Peripheral bus widths
  localparam int UA_W = 18;
  localparam int CT_W = 2;
  localparam int WD_W = 16;
  localparam int LW_W = 32;
  localparam int LVL_N = 4;
  localparam int MIDX_W = 9;
  localparam int MAP_N = 512;
  localparam int FRAME_W = 21;
  localparam int BPA_W = 28;
  localparam int WB_AW = 12;
  localparam int BE_W = 4;
  localparam int RAM_AW = 6;
  localparam int RAM_N = 64;
  localparam int TO_W = 16;
  // Address field positions
  localparam int PAGE_LSB = 9;
  localparam int LW_LSB = 2;
  localparam int WSEL_BIT = 1;
  localparam int BYTE_BIT = 0;
  localparam int AD_W = UA_W - LW_LSB;
  // Cycle type codes
  localparam logic [1:0] CT_WORD_READ = 2'h0;
  localparam logic [1:0] CT_READ_PAUSE = 2'h1;
  localparam logic [1:0] CT_WORD_WRITE = 2'h2;
  localparam logic [1:0] CT_BYTE_WRITE = 2'h3;
  localparam int CT_WRITE_BIT = 1;
  localparam logic [2:0] OFS_SPILL = 3'h7;
  // Upper end of the mapped range, exclusive; the I/O page stays unmapped
  localparam logic [17:0] MAP_LIMIT = 18'h3E000;
  // Buffered-path storage locations for the saved address
  localparam logic [5:0] BP_LOC_LO = 6'h17;
  localparam logic [5:0] BP_LOC_HI = 6'h21;
  // Backplane byte masks
  localparam logic [3:0] MASK_ALL = 4'hF;
  localparam logic [3:0] MASK_LO = 4'h3;
  localparam logic [3:0] MASK_HI = 4'hC;
  localparam logic [3:0] MASK_B0 = 4'h1;
  localparam logic [3:0] MASK_B3 = 4'h8;
  // Register byte offsets
  localparam logic [11:0] R_CTRL = 12'h000;
  localparam logic [11:0] R_STAT = 12'h004;
  localparam logic [11:0] R_SWCA = 12'h008;
  localparam logic [11:0] R_SWWD = 12'h00C;
  localparam logic [11:0] R_SWRD = 12'h010;
  localparam logic [11:0] R_HOLD = 12'h014;
  localparam logic [11:0] R_PURGE = 12'h018;
  localparam logic [11:0] R_LVL = 12'h01C;
  localparam int MAP_SEL_BIT = 11;
  // Register fields
  localparam int CTRL_IRQEN = 5;
  localparam int CTRL_FSEL = 6;
  localparam int STAT_SELTO = 1;
  localparam int STAT_MASTER = 2;
  localparam int STAT_SWPEND = 3;
  localparam int STAT_BUSY = 4;
  localparam int STAT_BPV = 5;
  localparam int SWCA_A10_LSB = 16;
  localparam int SWCA_CT_LSB = 18;
  localparam int MAP_V_BIT = 31;
  localparam int MAP_BP_BIT = 30;
  // Timing
  localparam int CLK_NS = 8;
  localparam int BPC_NS = 200;
  localparam int SEL_TO_BPC = 256;
  localparam int SEL_TO_NS = SEL_TO_BPC * BPC_NS;
  // Sequencer states
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_DWR = 6'h02,
    S_DRD = 6'h04,
    S_RD2 = 6'h08,
    S_PREF = 6'h10,
    S_PURGE = 6'h20
  } pbai_seq_type;
endpackage
`default_nettype wire

// ==== design/pbai_sync.sv ====
`default_nettype none
module pbai_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } pbai_sync_type;
  pbai_sync_type s_ff;
  pbai_sync_type nxt_s;

  // First stage feeds only the second
  always_comb begin
    nxt_s.meta = d_i;
    nxt_s.stab = s_ff.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else if (ce_i) begin
      s_ff <= nxt_s;
    end
  end

  assign q_o = s_ff.stab;
endmodule // pbai_sync
`default_nettype wire

// ==== design/pbai_top.sv ====
// Behaviour
// - Relay arbitration lines between both cable sides
// - Idle: pass address, upper nine select map
// - Launch only if valid, idle, ranged, qualified
// - Buffered write saves upper address bits
// - Purge routes saved address to map
// - Buffered spill write saves incremented address
// - Emptied buffered read triggers prefetch
// - Buffered spill read takes two backplane reads
// - Increment moves longword, may change page
// - Software address from command word
// - Drive address only as bus master
// - Gate bus data on inbound transfers
// - DMA read picks half by bit one
// - Software write picks half of longword
// - Enable data drivers on outbound transfers
// - Level requests follow control bits five, six
// - Request bus for three causes
// - Grant during level service becomes level grant
// - Own pending transfer absorbs grant
// - Otherwise pass grant to devices
// - Select timeout sets status, drops request
`default_nettype none
module pbai_top #(
  parameter int SEL_TO_CYC = pbai_pkg::SEL_TO_NS / pbai_pkg::CLK_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [pbai_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [pbai_pkg::LW_W-1:0] wb_dat_i,
  input wire logic [pbai_pkg::BE_W-1:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [pbai_pkg::LW_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dev_dma_request_i,
  input wire logic dev_selection_ack_i,
  input wire logic dev_vector_strobe_i,
  input wire logic [pbai_pkg::LVL_N-1:0] dev_irq_level_request_i,
  input wire logic [pbai_pkg::UA_W-1:0] dev_addr_i,
  input wire logic [pbai_pkg::CT_W-1:0] dev_cycle_type_code_i,
  input wire logic [pbai_pkg::WD_W-1:0] dev_data_i,
  input wire logic dev_master_sync_i,
  input wire logic dev_slave_sync_i,
  input wire logic bus_init_i,
  input wire logic term_dma_grant_i,
  input wire logic [pbai_pkg::LVL_N-1:0] term_irq_level_grant_i,
  output logic dev_dma_grant_o,
  output logic [pbai_pkg::LVL_N-1:0] dev_irq_level_grant_o,
  output logic dev_slave_sync_o,
  output logic dev_master_sync_o,
  output logic [pbai_pkg::UA_W-1:0] bus_addr_o,
  output logic [pbai_pkg::CT_W-1:0] bus_cycle_type_code_o,
  output logic bus_addr_oe_o,
  output logic [pbai_pkg::WD_W-1:0] bus_data_o,
  output logic bus_data_oe_o,
  output logic bus_busy_line_o,
  output logic term_dma_request_o,
  output logic term_selection_ack_o,
  output logic term_vector_strobe_o,
  output logic [pbai_pkg::LVL_N-1:0] term_irq_level_request_o,
  output logic [pbai_pkg::LVL_N-1:0] cpu_level_irq_o,
  output logic sel_timeout_o,
  output logic bp_req_o,
  output logic bp_we_o,
  output logic [pbai_pkg::BPA_W-1:0] bp_addr_o,
  output logic [pbai_pkg::LW_W-1:0] bp_wdata_o,
  output logic [pbai_pkg::BE_W-1:0] bp_mask_o,
  input wire logic bp_ack_i,
  input wire logic [pbai_pkg::LW_W-1:0] bp_rdata_i
);
  import pbai_pkg::*;

  typedef struct packed {
    logic ack;
    logic [LW_W-1:0] dat;
    logic fsel;
    logic irqen;
    logic selto;
    pbai_seq_type seq;
    logic [UA_W-1:0] hold;
    logic [CT_W-1:0] hct;
    logic spill;
    logic via_bp;
    logic bpv;
    logic svd;
    logic [LW_W-1:0] bpw;
    logic [BPA_W-1:0] bpa;
    logic breq;
    logic bwe;
    logic [LW_W-1:0] bwd;
    logic [BE_W-1:0] bmask;
    logic [WD_W-1:0] dout;
    logic reply;
    logic [UA_W-1:0] swa;
    logic [CT_W-1:0] swct;
    logic swp;
    logic mst;
    logic [LW_W-1:0] swl;
    logic [WD_W-1:0] swr;
    logic [TO_W-1:0] tocnt;
    logic [LVL_N-1:0] lvl;
  } pbai_regs_type;

  localparam pbai_regs_type RST_VAL = '{seq: S_IDLE, default: '0};
  localparam int CTL_W = 7 + 2 * LVL_N;
  localparam int DAT_W = UA_W + CT_W + WD_W;

  pbai_regs_type s_ff;
  pbai_regs_type nxt_s;
  logic [LW_W-1:0] map_mem [MAP_N];
  logic [7:0] bp_ram [RAM_N];
  logic map_we;
  logic [LW_W-1:0] map_wd;
  logic ram_we;
  logic [WD_W-1:0] ram_val;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; arbitration must never see a half-settled level
  logic [CTL_W-1:0] ctl_s;
  logic [DAT_W-1:0] dat_s;
  logic s_dreq, s_selection_ack, s_vstb, s_grant, s_msyn, s_ssyn, s_init;
  logic [LVL_N-1:0] s_lvl, s_tlvl;
  logic [UA_W-1:0] s_addr;
  logic [CT_W-1:0] s_ct;
  logic [WD_W-1:0] s_data;

  pbai_sync #(.W(CTL_W)) u_sync_ctl (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({dev_dma_request_i, dev_selection_ack_i, dev_vector_strobe_i,
          dev_irq_level_request_i, term_dma_grant_i,
          term_irq_level_grant_i, dev_master_sync_i, dev_slave_sync_i,
          bus_init_i}),
    .q_o(ctl_s)
  );
  pbai_sync #(.W(DAT_W)) u_sync_dat (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({dev_addr_i, dev_cycle_type_code_i, dev_data_i}),
    .q_o(dat_s)
  );
  assign {s_dreq, s_selection_ack, s_vstb, s_lvl, s_grant, s_tlvl, s_msyn, s_ssyn,
          s_init} = ctl_s;
  assign {s_addr, s_ct, s_data} = dat_s;

  ////////////////////////////////////////////////////////////////////////
  // Internal address bus and map lookup
  logic idle;
  logic [AD_W-1:0] saved;
  logic [UA_W-1:0] ad_bus;
  logic [UA_W-1:0] inc;
  logic [LW_W-1:0] map_ent;
  logic [BPA_W-1:0] bp_form;
  logic [2:0] ofs_new;
  logic launch_ok;
  logic take;

  assign idle = (s_ff.seq == S_IDLE);
  assign saved = {bp_ram[BP_LOC_HI], bp_ram[BP_LOC_LO]};
  assign ad_bus = idle ? s_addr :
    (s_ff.seq == S_PURGE) ? {saved, 2'h0} : s_ff.hold;
  assign inc = {s_ff.hold[UA_W-1:LW_LSB] + 16'h0001, 2'h0};
  assign map_ent = map_mem[ad_bus[UA_W-1:PAGE_LSB]];
  assign bp_form = {map_ent[FRAME_W-1:0],
                    ad_bus[PAGE_LSB-1:LW_LSB]};
  assign ofs_new = {s_addr[BYTE_BIT], s_addr[LW_LSB], s_addr[WSEL_BIT]};
  // Device owns address pins while it holds master sync
  assign launch_ok = idle && s_msyn && !s_ff.reply && !s_ff.mst &&
    map_ent[MAP_V_BIT] && (s_addr < MAP_LIMIT) &&
    (s_ct != CT_READ_PAUSE);
  // Grant absorbed only with no selection ack and no init on the bus
  assign take = s_grant && s_ff.swp && !s_ff.mst && !s_selection_ack &&
    !s_init && (s_ff.lvl == '0);

  function automatic logic [LW_W-1:0] merge(input logic [LW_W-1:0] o,
      input logic [LW_W-1:0] d, input logic [BE_W-1:0] be);
    logic [LW_W-1:0] r;
    r = o;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        r[8*i+:8] = d[8*i+:8];
      end
    end
    return r;
  endfunction

  function automatic logic [LW_W-1:0] reg_read(input logic [WB_AW-1:0] a);
    logic [LW_W-1:0] r;
    r = '0;
    if (a[MAP_SEL_BIT]) begin
      r = map_mem[a[MAP_SEL_BIT-1:LW_LSB]];
    end else begin
      unique case (a)
        R_CTRL: begin
          r[CTRL_IRQEN] = s_ff.irqen;
          r[CTRL_FSEL] = s_ff.fsel;
        end
        R_STAT: begin
          r[STAT_SELTO] = s_ff.selto;
          r[STAT_MASTER] = s_ff.mst;
          r[STAT_SWPEND] = s_ff.swp;
          r[STAT_BUSY] = !idle;
          r[STAT_BPV] = s_ff.bpv;
        end
        R_SWCA: r = {12'h000, s_ff.swct, s_ff.swa[1:0],
                     s_ff.swa[UA_W-1:LW_LSB]};
        R_SWWD: r = s_ff.swl;
        R_SWRD: r = {16'h0000, s_ff.swr};
        R_HOLD: r = {14'h0000, s_ff.hold};
        R_PURGE: r = {4'h0, s_ff.bpa};
        R_LVL: r = {28'h0000000, s_ff.lvl};
        default: r = '0;
      endcase
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  logic wb_req, wr;
  assign wb_req = wb_cyc_i && wb_stb_i && !s_ff.ack;
  assign wr = wb_cyc_i && wb_stb_i && s_ff.ack && wb_we_i;

  always_comb begin
    nxt_s = s_ff;
    map_we = 1'b0;
    map_wd = merge(map_mem[wb_adr_i[MAP_SEL_BIT-1:LW_LSB]], wb_dat_i,
                   wb_sel_i);
    ram_we = 1'b0;
    ram_val = s_ff.hold[UA_W-1:LW_LSB];
    // Bus slave: ack one cycle after the request, write on the ack edge
    nxt_s.ack = wb_req;
    if (wb_req) begin
      nxt_s.dat = reg_read(wb_adr_i);
    end
    if (wr && wb_adr_i[MAP_SEL_BIT]) begin
      map_we = 1'b1;
    end else if (wr) begin
      unique case (wb_adr_i)
        R_CTRL: if (wb_sel_i[0]) begin
          nxt_s.irqen = wb_dat_i[CTRL_IRQEN];
          nxt_s.fsel = wb_dat_i[CTRL_FSEL];
        end
        R_STAT: if (wb_dat_i[STAT_SELTO]) begin
          nxt_s.selto = 1'b0;
        end
        R_SWCA: if (!s_ff.swp && !s_ff.mst) begin
          nxt_s.swa = {wb_dat_i[15:0],
                       wb_dat_i[SWCA_A10_LSB+:2]};
          nxt_s.swct = wb_dat_i[SWCA_CT_LSB+:CT_W];
          nxt_s.swp = 1'b1;
          nxt_s.tocnt = '0;
        end
        R_SWWD: nxt_s.swl = merge(s_ff.swl, wb_dat_i, wb_sel_i);
        R_PURGE: if (idle && !s_ff.reply && s_ff.svd) begin
          nxt_s.seq = S_PURGE;
        end
        R_LVL: nxt_s.lvl = wb_dat_i[LVL_N-1:0];
        default: ;
      endcase
    end
    // Level service ends on the device's vector strobe
    if (s_vstb) begin
      nxt_s.lvl = '0;
    end
    // Idle: latches transparent; busy: frozen except for increments
    if (idle) begin
      nxt_s.hold = s_addr;
      nxt_s.hct = s_ct;
    end
    if (s_ff.reply && !s_msyn) begin
      nxt_s.reply = 1'b0;
    end
    if (launch_ok && nxt_s.seq == S_IDLE) begin
      nxt_s.via_bp = map_ent[MAP_BP_BIT];
      nxt_s.spill = (ofs_new == OFS_SPILL);
      nxt_s.breq = 1'b0;
      if (s_ct[CT_WRITE_BIT]) begin
        nxt_s.seq = S_DWR;
        nxt_s.bwd = {s_data, s_data};
        nxt_s.bpw = {s_data, s_data};
        nxt_s.bmask = (s_ct == CT_BYTE_WRITE) ?
          (MASK_B0 << s_addr[1:0]) :
          (s_addr[WSEL_BIT] ? MASK_HI : MASK_LO);
        if (map_ent[MAP_BP_BIT]) begin
          ram_we = 1'b1;
          ram_val = (ofs_new == OFS_SPILL) ?
            (s_addr[UA_W-1:LW_LSB] + 16'h0001) :
            s_addr[UA_W-1:LW_LSB];
          nxt_s.svd = 1'b1;
          nxt_s.bpv = 1'b1;
        end
      end else if (map_ent[MAP_BP_BIT] && s_ff.bpv &&
                   ofs_new != OFS_SPILL) begin
        // Data already buffered: answer now, then refill
        nxt_s.dout = s_addr[WSEL_BIT] ? s_ff.bpw[31:16] :
          s_ff.bpw[15:0];
        nxt_s.reply = 1'b1;
        nxt_s.bpv = 1'b0;
        nxt_s.hold = {s_addr[UA_W-1:LW_LSB] + 16'h0001, 2'h0};
        nxt_s.seq = S_PREF;
      end else begin
        nxt_s.seq = S_DRD;
      end
    end
    // Backplane request per state: issue, then wait for ack
    if (!idle && !s_ff.breq) begin
      nxt_s.breq = 1'b1;
      nxt_s.bpa = bp_form;
      nxt_s.bwe = (s_ff.seq == S_DWR) || (s_ff.seq == S_PURGE);
      if (s_ff.seq == S_DRD) begin
        // Buffered spill read: first pass fetches only the top byte
        nxt_s.bmask = (s_ff.spill && s_ff.via_bp) ? MASK_B3 : MASK_ALL;
      end else if (s_ff.seq == S_RD2) begin
        nxt_s.bmask = MASK_B0;
      end else if (s_ff.seq != S_DWR) begin
        nxt_s.bmask = MASK_ALL;
      end
      if (s_ff.seq == S_PURGE) begin
        nxt_s.bwd = s_ff.bpw;
      end
    end else if (s_ff.breq && bp_ack_i) begin
      nxt_s.breq = 1'b0;
      nxt_s.seq = S_IDLE;
      unique case (s_ff.seq)
        S_DWR: nxt_s.reply = 1'b1;
        S_DRD: if (s_ff.spill && s_ff.via_bp) begin
          nxt_s.dout[7:0] = bp_rdata_i[31:24];
          nxt_s.hold = inc;
          nxt_s.seq = S_RD2;
        end else begin
          nxt_s.dout = s_ff.hold[WSEL_BIT] ? bp_rdata_i[31:16] :
            bp_rdata_i[15:0];
          nxt_s.reply = 1'b1;
          if (s_ff.via_bp) begin
            nxt_s.hold = inc;
            nxt_s.seq = S_PREF;
          end
        end
        S_RD2: begin
          nxt_s.dout[15:8] = bp_rdata_i[7:0];
          nxt_s.reply = 1'b1;
        end
        S_PREF: begin
          nxt_s.bpw = bp_rdata_i;
          nxt_s.bpv = 1'b1;
        end
        S_PURGE: nxt_s.bpv = 1'b0;
        default: ;
      endcase
    end
    // Software transfer: select timeout, grant, slave answer
    if (s_ff.swp && !take) begin
      nxt_s.tocnt = s_ff.tocnt + 16'h0001;
      if (s_ff.tocnt == TO_W'(SEL_TO_CYC - 1)) begin
        nxt_s.selto = 1'b1;
        nxt_s.swp = 1'b0;
      end
    end
    if (take) begin
      nxt_s.mst = 1'b1;
      nxt_s.swp = 1'b0;
    end
    if (s_ff.mst && s_ssyn) begin
      nxt_s.mst = 1'b0;
      if (!s_ff.swct[CT_WRITE_BIT]) begin
        nxt_s.swr = s_data;
      end
    end
    if (s_init) begin
      nxt_s.swp = 1'b0;
      nxt_s.mst = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= RST_VAL;
    end else if (ce_i) begin
      s_ff <= nxt_s;
      if (map_we) begin
        map_mem[wb_adr_i[MAP_SEL_BIT-1:LW_LSB]] <= map_wd;
      end
      if (ram_we) begin
        bp_ram[BP_LOC_LO] <= ram_val[7:0];
        bp_ram[BP_LOC_HI] <= ram_val[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; relays pass through synchronised levels only
  logic lvl_busy;
  assign lvl_busy = (s_ff.lvl != '0);
  assign wb_ack_o = s_ff.ack;
  assign wb_dat_o = s_ff.dat;
  // One request at a time on the bus, so relay and own share a line
  assign term_dma_request_o = s_dreq || s_ff.swp || lvl_busy;
  assign term_selection_ack_o = s_selection_ack || s_ff.mst;
  assign term_vector_strobe_o = s_vstb;
  assign term_irq_level_request_o = s_ff.fsel ? '0 : s_lvl;
  assign cpu_level_irq_o = (s_ff.fsel && s_ff.irqen) ? s_lvl : '0;
  assign dev_dma_grant_o = s_grant && !lvl_busy && !s_ff.swp &&
    !s_ff.mst;
  assign dev_irq_level_grant_o = s_ff.fsel ?
    (s_grant ? (s_ff.lvl & s_lvl) : '0) : s_tlvl;
  assign dev_slave_sync_o = s_ff.reply;
  assign dev_master_sync_o = s_ff.mst;
  assign bus_busy_line_o = s_ff.mst;
  assign bus_addr_oe_o = s_ff.mst;
  assign bus_addr_o = s_ff.swa;
  assign bus_cycle_type_code_o = s_ff.swct;
  // Direction from the answered cycle, not the last backplane request
  assign bus_data_oe_o = s_ff.reply && !s_ff.hct[CT_WRITE_BIT] ||
    s_ff.mst && s_ff.swct[CT_WRITE_BIT];
  assign bus_data_o = s_ff.mst ? (s_ff.swa[WSEL_BIT] ?
    s_ff.swl[31:16] : s_ff.swl[15:0]) : s_ff.dout;
  assign sel_timeout_o = s_ff.selto;
  assign bp_req_o = s_ff.breq;
  assign bp_we_o = s_ff.bwe;
  assign bp_addr_o = s_ff.bpa;
  assign bp_wdata_o = s_ff.bwd;
  assign bp_mask_o = s_ff.bmask;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_vector_relay: assert property (ce_i && $past(ce_i) &&
    $past(dev_vector_strobe_i, 2) && $past(ce_i, 2) |->
    term_vector_strobe_o) else $error("vector strobe not relayed");
  a_launch_cond: assert property (ce_i && idle &&
    (nxt_s.seq == S_DWR || nxt_s.seq == S_DRD) |->
    map_ent[MAP_V_BIT] && s_addr < MAP_LIMIT && s_ct != CT_READ_PAUSE)
    else $error("launch without qualifying conditions");
  a_addr_master: assert property (bus_addr_oe_o |->
    bus_busy_line_o && dev_master_sync_o && !dev_dma_grant_o)
    else $error("address driven while not master");
  a_level_block: assert property (s_grant && lvl_busy |->
    !dev_dma_grant_o) else $error("grant leaked during level service");
  a_take_grant: assert property (ce_i && take && !s_init |=>
    bus_busy_line_o && term_selection_ack_o)
    else $error("pending transfer did not absorb grant");
  a_fwd_mode: assert property (!s_ff.fsel |->
    cpu_level_irq_o == '0 && term_irq_level_request_o == s_lvl)
    else $error("level request routed wrongly");
  a_word_half: assert property (ce_i && s_ff.seq == S_DRD &&
    s_ff.breq && bp_ack_i && !(s_ff.spill && s_ff.via_bp) |=>
    bus_data_o == ($past(s_ff.hold[WSEL_BIT]) ?
    $past(bp_rdata_i[31:16]) : $past(bp_rdata_i[15:0])))
    else $error("wrong read half on bus");
  a_select_to: assert property (ce_i && s_ff.swp && !take &&
    s_ff.tocnt == TO_W'(SEL_TO_CYC - 1) |=>
    sel_timeout_o && !s_ff.swp) else $error("select timeout missed");
  a_inc_long: assert property (ce_i && s_ff.seq == S_DRD &&
    nxt_s.seq == S_RD2 |=> s_ff.hold[1:0] == 2'h0 &&
    s_ff.hold[UA_W-1:LW_LSB] == $past(s_ff.hold[UA_W-1:LW_LSB]) + 16'h0001)
    else $error("increment not to next longword");
  a_hold_frozen: assert property (ce_i && s_ff.seq == S_DWR |=>
    $stable(s_ff.hold)) else $error("hold changed while busy");

  c_take: cover property (take ##1 s_ff.mst);
  c_spill_read: cover property (s_ff.seq == S_RD2 ##[1:20] s_ff.reply);
  c_prefetch: cover property (s_ff.seq == S_PREF ##[1:20] s_ff.bpv);
  c_timeout: cover property ($rose(sel_timeout_o));
endmodule // pbai_top
`default_nettype wire

// ==== sim/pbai_term_model.sv ====
`default_nettype none
module pbai_term_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic selection_ack_i,
  input wire logic init_i,
  input wire logic hold_i,
  output logic grant_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Hold stalls arbitration so a select timeout can happen
  always @(posedge clk_i) begin
    grant_o <= req_i && !selection_ack_i && !init_i && !hold_i;
  end
endmodule // pbai_term_model
`default_nettype wire

// ==== sim/pbai_top_test.sv ====
`default_nettype none
module pbai_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pbai_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, hold = 1'b0, sso = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [31:0] wb_dat_i = 32'h0, bp_rdata_i = 32'h0, bpd = 32'h0;
  logic [3:0] wb_sel_i = 4'hF, dev_irq_level_request_i = 4'h0, lr;
  logic [3:0] term_irq_level_grant_i = 4'h0;
  logic wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, bp_ack_i = 0;
  logic dev_dma_request_i = 0, dev_selection_ack_i = 0;
  logic dev_vector_strobe_i = 0, dev_master_sync_i = 0;
  logic dev_slave_sync_i = 0, bus_init_i = 0, term_dma_grant_i;
  logic [17:0] dev_addr_i = 18'h0, bus_addr_o;
  logic [1:0] dev_cycle_type_code_i = 2'h0, bus_cycle_type_code_o;
  logic [15:0] dev_data_i = 16'h0, bus_data_o, wd = 16'h0;
  logic [31:0] wb_dat_o, bp_wdata_o, rq[$], mq[$], dq[$], bq[$];
  logic wb_ack_o, dev_dma_grant_o, dev_slave_sync_o, dev_master_sync_o;
  logic bus_addr_oe_o, bus_data_oe_o, bus_busy_line_o, term_dma_request_o;
  logic term_selection_ack_o, term_vector_strobe_o, sel_timeout_o;
  logic bp_req_o, bp_we_o;
  logic [3:0] dev_irq_level_grant_o, term_irq_level_request_o;
  logic [3:0] cpu_level_irq_o, bp_mask_o;
  logic [27:0] bp_addr_o;
  logic [7:0] cv[4] = '{8'h60, 8'h40, 8'h20, 8'h00};
  int err_total = 0, check_count = 0, n = 0;
  // Short select timeout keeps the run brief
  pbai_top #(.SEL_TO_CYC(40)) u_pbai_top (.*);
  pbai_term_model u_pbai_term_model (.clk_i(clk_i),
    .req_i(term_dma_request_o), .selection_ack_i(term_selection_ack_o),
    .init_i(bus_init_i), .hold_i(hold), .grant_o(term_dma_grant_i));
  initial forever #4 clk_i = ~clk_i;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk1(input string s, input logic e, g);
    chk(s, {31'h0, e}, {31'h0, g});
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wb(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    // Wait ends on wb_ack_o, or the bench timeout if no ack comes
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, m);
    rq.push_back(e);
    mq.push_back(m);
    wb(a, 1'b0, 32'h0);
  endtask
  task automatic dma(input logic [17:0] a, input logic [1:0] t,
    input logic ok);
    int k;
    k = 0;
    dev_addr_i <= a;
    dev_cycle_type_code_i <= t;
    dev_master_sync_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (dev_slave_sync_o !== 1'b1 && k < 60);
    chk1("dma answer", ok, k < 60);
    chk1("bus_data_oe_o", ok && !t[CT_WRITE_BIT], bus_data_oe_o);
    dev_master_sync_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    n++;
    if (n > 20000) begin
      err_total++;
      print_verdict();
    end
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rq.size() > 0)
      chk("wb_dat_o", rq.pop_front(), wb_dat_o & mq.pop_front());
    sso <= dev_slave_sync_o;
    if (dev_slave_sync_o === 1'b1 && sso === 1'b0 && dq.size() > 0) begin
      chk("bus_data_o", dq.pop_front(), {16'h0, bus_data_o});
      chk1("bus_data_oe_o", 1'b1, bus_data_oe_o);
    end
    // Prompt backplane; one ack per request, then a gap
    bp_ack_i <= 1'b0;
    if (bp_req_o === 1'b1 && bp_ack_i === 1'b0) begin
      chk("bp_addr_o", {4'h0, 21'h12345, 7'h11}, {4'h0, bp_addr_o});
      if (bq.size() > 0)
        chk("bp_mask", bq.pop_front(), {27'h0, bp_we_o, bp_mask_o});
      if (bp_we_o === 1'b1)
        chk("bp_wdata_o", {wd, wd}, bp_wdata_o);
      bp_ack_i <= 1'b1;
      bp_rdata_i <= bpd;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h604a));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(R_STAT, 32'h0, 32'h3E);
    foreach (cv[i]) begin
      lr = 4'($urandom_range(15, 1));
      wb(R_CTRL, 1'b1, {24'h0, cv[i]});
      dev_irq_level_request_i <= lr;
      repeat (5) @(posedge clk_i);
      chk("cpu_level_irq_o", (cv[i] == 8'h60) ? lr : 0, cpu_level_irq_o);
      chk("term_irq_lvl", cv[i][6] ? 0 : lr, term_irq_level_request_o);
      dev_irq_level_request_i <= 4'h0;
    end
    dev_dma_request_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk1("term_dma_request_o", 1'b1, term_dma_request_o);
    chk1("dev_dma_grant_o", 1'b1, dev_dma_grant_o);
    dev_selection_ack_i <= 1'b1;
    dev_dma_request_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk1("term_selection_ack_o", 1'b1, term_selection_ack_o);
    dev_selection_ack_i <= 1'b0;
    wb(12'h814, 1'b1, {11'h400, 21'h12345});
    for (int j = 0; j < 2; j++) begin
      bpd = $urandom;
      dq.push_back({16'h0, j ? bpd[31:16] : bpd[15:0]});
      bq.push_back({27'h0, 1'b0, MASK_ALL});
      dma(18'h00A44 | 18'(j << 1), CT_WORD_READ, 1'b1);
    end
    wd = 16'($urandom);
    dev_data_i <= wd;
    bq.push_back({27'h0, 1'b1, MASK_HI});
    dma(18'h00A46, CT_WORD_WRITE, 1'b1);
    dma(18'h00A44, CT_READ_PAUSE, 1'b0);
    hold <= 1'b1;
    wb(R_SWCA, 1'b1, 32'h0001_2345);
    chk1("term_dma_request_o", 1'b1, term_dma_request_o);
    // Frozen clock enable must also freeze the select timeout
    ce_i <= 1'b0;
    repeat (45) @(posedge clk_i);
    chk1("sel_timeout_o", 1'b0, sel_timeout_o);
    ce_i <= 1'b1;
    repeat (60) @(posedge clk_i);
    chk1("sel_timeout_o", 1'b1, sel_timeout_o);
    chk1("term_dma_request_o", 1'b0, term_dma_request_o);
    rd(R_STAT, 32'h2, 32'h2);
    wb(R_STAT, 1'b1, 32'h2);
    hold <= 1'b0;
    wb(R_SWCA, 1'b1, 32'h0003_1234);
    for (int k = 0; k < 30 && bus_busy_line_o !== 1'b1; k++)
      @(posedge clk_i);
    chk1("bus_busy_line_o", 1'b1, bus_busy_line_o);
    chk1("term_selection_ack_o", 1'b1, term_selection_ack_o);
    chk1("dev_dma_grant_o", 1'b0, dev_dma_grant_o);
    chk1("bus_addr_oe_o", 1'b1, bus_addr_oe_o);
    chk("bus_addr_o", 32'h48D3, {14'h0, bus_addr_o});
    chk("bus_cycle_type_code_o", CT_WORD_READ, bus_cycle_type_code_o);
    chk1("dev_master_sync_o", 1'b1, dev_master_sync_o);
    wd = 16'($urandom);
    dev_data_i <= wd;
    dev_slave_sync_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    dev_slave_sync_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(R_SWRD, {16'h0, wd}, 32'hFFFF);
    // Level service: grant turns into a level grant
    wb(R_CTRL, 1'b1, 32'h40);
    dev_irq_level_request_i <= 4'h2;
    wb(R_LVL, 1'b1, 32'h2);
    repeat (8) @(posedge clk_i);
    chk("irq_level_grant", 32'h2, {28'h0, dev_irq_level_grant_o});
    chk1("dev_dma_grant_o", 1'b0, dev_dma_grant_o);
    dev_vector_strobe_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk1("term_vector_strobe_o", 1'b1, term_vector_strobe_o);
    dev_vector_strobe_i <= 1'b0;
    dev_irq_level_request_i <= 4'h0;
    repeat (6) @(posedge clk_i);
    print_verdict();
  end
endmodule // pbai_top_test
`default_nettype wire
